/* core/dsp_reset_consts.svh */
// Constants of the core reset and bus-quiescing block
`ifndef DSP_RESET_CONSTS_SVH
`define DSP_RESET_CONSTS_SVH
`define MC_DIV 3'h4
`define ADDR_RESET 12'h000
`define PC_RESET 12'h000
`define RESET_MIN_CYCLES 3'h5
`endif

/* core/dsp_reset_pkg.sv */
// Types of the core reset and bus-quiescing block
package dsp_reset_pkg;
    typedef enum logic [2:0] {
        ST_RESET = 3'b001,
        ST_WAIT = 3'b010,
        ST_RUN = 3'b100
    } seq_type;
    typedef struct packed {
        logic dataSpace;
        logic write;
        logic progMem;
    } strobe_type;
endpackage : dsp_reset_pkg

/* core/dsp_core_reset_sync.sv */
// Reset synchronisation, strobe quiescing and fetch restart of the core
`timescale 1ns/10ps
`default_nettype none
`include "dsp_reset_consts.svh"
module dsp_core_reset_sync (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic reset_in_n,
    input wire logic interrupt_req_n,
    input wire logic branch_input_n,
    input wire logic fetchReq,
    input wire logic dataReq,
    input wire logic writeReq,
    input wire logic [15:0] writeData,
    input wire logic [11:0] dataAddr,
    output logic cpu_clock_out,
    output logic data_space_strobe_n,
    output logic write_strobe_n,
    output logic program_memory_strobe_n,
    output logic [11:0] addr_bus_out,
    output logic [15:0] dataOut,
    output logic [15:0] dataOe,
    output logic [11:0] progCounter,
    output logic coreInReset,
    output logic intSampled,
    output logic branchSampled
);
    logic [1:0] rsSync_r;
    logic [1:0] phase_r;
    logic mcEnd;
    logic rsLow;
    dsp_reset_pkg::seq_type state_r;
    dsp_reset_pkg::strobe_type strb_nxt;
    logic [1:0] intSync_r;
    logic [1:0] bioSync_r;
    logic clrArm_r;

    // Two-flop synchroniser; tolerates any edge position
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rsSync_r <= 2'h0;
        end else begin
            rsSync_r <= {rsSync_r[0], reset_in_n};
        end
    end
    assign rsLow = !rsSync_r[1];

    // Machine cycle of four input clocks
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            phase_r <= 2'h0;
            cpu_clock_out <= 1'b1;
        end else begin
            phase_r <= phase_r + 2'h1;
            cpu_clock_out <= (phase_r == 2'h3) || (phase_r == 2'h0);
        end
    end
    assign mcEnd = (phase_r == 2'(`MC_DIV - 3'h1));

    // Sequencer: wait a full machine cycle after the synchronised release edge; enter reset at once
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_r <= dsp_reset_pkg::ST_RESET;
        end else begin
            case (state_r)
                dsp_reset_pkg::ST_RESET: begin
                    if (!rsLow && mcEnd) begin
                        state_r <= dsp_reset_pkg::ST_WAIT;
                    end
                end
                dsp_reset_pkg::ST_WAIT: begin
                    if (rsLow) begin
                        state_r <= dsp_reset_pkg::ST_RESET;
                    end else if (mcEnd) begin
                        state_r <= dsp_reset_pkg::ST_RUN;
                    end
                end
                dsp_reset_pkg::ST_RUN: begin
                    if (rsLow) begin
                        state_r <= dsp_reset_pkg::ST_RESET;
                    end
                end
                default: state_r <= dsp_reset_pkg::ST_RESET;
            endcase
        end
    end

    // One strobe at most, fetch has priority over data access
    always_comb begin
        strb_nxt = '{dataSpace: 1'b1, write: 1'b1, progMem: 1'b1};
        if (state_r == dsp_reset_pkg::ST_RUN && !rsLow) begin
            if (fetchReq) begin
                strb_nxt.progMem = 1'b0;
            end else if (writeReq) begin
                strb_nxt.write = 1'b0;
            end else if (dataReq) begin
                strb_nxt.dataSpace = 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            data_space_strobe_n <= 1'b1;
            write_strobe_n <= 1'b1;
            program_memory_strobe_n <= 1'b1;
            dataOe <= 16'h0000;
            dataOut <= 16'h0000;
        end else begin
            // Strobes high and bus floated immediately on synchronised reset
            data_space_strobe_n <= strb_nxt.dataSpace;
            write_strobe_n <= strb_nxt.write;
            program_memory_strobe_n <= strb_nxt.progMem;
            dataOe <= {16{!strb_nxt.write}};
            // Data of a write cut by reset is not guaranteed
            dataOut <= writeData;
        end
    end

    // Arm at the first boundary seen in reset; clearing at that boundary
    // would cut the machine cycle short, so a whole cycle must follow it
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            clrArm_r <= 1'b0;
        end else if (!rsLow) begin
            clrArm_r <= 1'b0;
        end else if (mcEnd) begin
            clrArm_r <= 1'b1;
        end
    end

    // Address and PC clear one whole machine cycle into reset
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            addr_bus_out <= `ADDR_RESET;
            progCounter <= `PC_RESET;
        end else if (state_r != dsp_reset_pkg::ST_RUN) begin
            if (mcEnd && clrArm_r) begin
                addr_bus_out <= `ADDR_RESET;
                progCounter <= `PC_RESET;
            end
        end else if (strb_nxt.progMem == 1'b0) begin
            addr_bus_out <= progCounter;
            progCounter <= progCounter + 12'h001;
        end else if (!strb_nxt.write || !strb_nxt.dataSpace) begin
            // Address may be stale if reset lands mid write
            addr_bus_out <= dataAddr;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            coreInReset <= 1'b1;
        end else begin
            coreInReset <= (state_r != dsp_reset_pkg::ST_RUN);
        end
    end

    // Pin synchronisers, then one capture per machine cycle
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            intSync_r <= 2'h3;
            bioSync_r <= 2'h3;
            intSampled <= 1'b0;
            branchSampled <= 1'b0;
        end else begin
            intSync_r <= {intSync_r[0], interrupt_req_n};
            bioSync_r <= {bioSync_r[0], branch_input_n};
            if (mcEnd) begin
                intSampled <= !intSync_r[1];
                branchSampled <= !bioSync_r[1];
            end
        end
    end

    AST_STROBE_EXCL: assert property (@(posedge clk) disable iff (!rst_b)
        (data_space_strobe_n + write_strobe_n + program_memory_strobe_n) >= 2'd2)
        else $error("More than one strobe low");
    AST_RESET_QUIET: assert property (@(posedge clk) disable iff (!rst_b)
        rsLow |=> (data_space_strobe_n && write_strobe_n && program_memory_strobe_n
        && dataOe == 16'h0000))
        else $error("Bus not quiet during reset");
    AST_ADDR_CLEAR: assert property (@(posedge clk) disable iff (!rst_b)
        $fell(rsSync_r[1]) |-> ##[5:8] (addr_bus_out == 12'h000 && progCounter == 12'h000))
        else $error("Address not cleared after reset");
    AST_RESUME: assert property (@(posedge clk) disable iff (!rst_b)
        $rose(rsSync_r[1]) ##1 (!rsLow) [*8] |-> state_r == dsp_reset_pkg::ST_RUN)
        else $error("Fetch did not resume");
    AST_NO_EARLY: assert property (@(posedge clk) disable iff (!rst_b)
        $rose(rsSync_r[1]) |=> (state_r != dsp_reset_pkg::ST_RUN) [*4])
        else $error("Fetch resumed too early");
    AST_CLK_PERIOD: assert property (@(posedge clk) disable iff (!rst_b)
        $rose(cpu_clock_out) |=> $stable(cpu_clock_out) ##1 $fell(cpu_clock_out))
        else $error("Machine clock high phase wrong");
    AST_FIRST_FETCH: assert property (@(posedge clk) disable iff (!rst_b)
        ($past(state_r, 2) != dsp_reset_pkg::ST_RUN && !program_memory_strobe_n
        && $fell(program_memory_strobe_n)) |-> addr_bus_out == 12'h000)
        else $error("First fetch not from zero");
    AST_SAMPLE: assert property (@(posedge clk) disable iff (!rst_b)
        !mcEnd |=> $stable(intSampled) && $stable(branchSampled))
        else $error("Sample changed off machine-cycle boundary");

    // Pin-level checks on what the block drives
    AST_CLK_LOW: assert property (@(posedge clk) disable iff (!rst_b)
        $fell(cpu_clock_out) |=> !cpu_clock_out ##1 $rose(cpu_clock_out))
        else $error("Machine clock low phase wrong");
    AST_QUIET_IDLE: assert property (@(posedge clk) disable iff (!rst_b)
        state_r != dsp_reset_pkg::ST_RUN |=> (data_space_strobe_n && write_strobe_n
        && program_memory_strobe_n))
        else $error("Strobe while not running");
    AST_PC_STEP: assert property (@(posedge clk) disable iff (!rst_b)
        !program_memory_strobe_n |-> progCounter == addr_bus_out + 12'h001)
        else $error("Counter not one past fetch address");
    AST_DRIVE_WRITE: assert property (@(posedge clk) disable iff (!rst_b)
        dataOe == (write_strobe_n ? 16'h0000 : 16'hFFFF))
        else $error("Data bus driven outside write");
endmodule : dsp_core_reset_sync
`default_nettype wire

/* dv/reset_source.sv */
// Model of the external reset source
`timescale 1ns/10ps
`default_nettype none
module reset_source #(
    parameter int LOW_CYCLES = 20
) (
    input wire logic clk,
    input wire logic go,
    output logic reset_in_n
);
    int cnt = 0;
    always @(posedge clk) begin
        if (go) cnt <= LOW_CYCLES;
        else if (cnt > 0) cnt <= cnt - 1;
    end
    // Edge lands 7 to 8 ns after a rising clock edge, off the sampling edge
    assign #7 reset_in_n = !(go || cnt > 0);
endmodule : reset_source
`default_nettype wire

/* dv/dsp_core_reset_sync_tb_top.sv */
// Testbench of the core reset block
`timescale 1ns/10ps
`default_nettype none
module dsp_core_reset_sync_tb_top;
    logic clk = 1'b0, rstB = 1'b0, go = 1'b0, intN = 1'b1, brN = 1'b1, fReq = 1'b0;
    logic wReq = 1'b0, dReq = 1'b0;
    logic resetInN, cpuClk, dsN, wrN, pmN, inRst, intS, brS;
    logic [11:0] addr, pc;
    logic [15:0] dOe, dOut;
    int errors = 0, checked = 0, n;
    time t0;
    always #20 clk = ~clk;
    reset_source reset_source_i (.clk(clk), .go(go), .reset_in_n(resetInN));
    dsp_core_reset_sync dsp_core_reset_sync_i (.clk(clk), .rst_b(rstB),
        .reset_in_n(resetInN), .interrupt_req_n(intN), .branch_input_n(brN),
        .fetchReq(fReq), .dataReq(dReq), .writeReq(wReq), .writeData(16'hA5C3),
        .dataAddr(12'h5A5), .cpu_clock_out(cpuClk), .data_space_strobe_n(dsN),
        .write_strobe_n(wrN), .program_memory_strobe_n(pmN), .addr_bus_out(addr),
        .dataOut(dOut), .dataOe(dOe), .progCounter(pc), .coreInReset(inRst),
        .intSampled(intS), .branchSampled(brS));
    task automatic tick(int k);
        repeat (k) @(posedge clk);
        #1;
    endtask : tick
    task automatic chk(string name, logic [15:0] exp, logic [15:0] got);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    task automatic t_clock();
        @(posedge cpuClk);
        t0 = $time;
        @(posedge cpuClk);
        chk("machine cycle ns", 16'h00A0, 16'($time - t0));
        tick(1);
    endtask : t_clock
    task automatic t_sample();
        intN = 1'b0;
        brN = 1'b0;
        tick(10);
        chk("int sampled", 16'h0001, {15'h0000, intS});
        chk("branch sampled", 16'h0001, {15'h0000, brS});
        intN = 1'b1;
        brN = 1'b1;
        tick(10);
        chk("int cleared", 16'h0000, {15'h0000, intS});
        chk("branch cleared", 16'h0000, {15'h0000, brS});
    endtask : t_sample
    task automatic t_reset();
        fReq = 1'b1;
        tick(4);
        fReq = 1'b0;
        dReq = 1'b1;
        tick(2);
        chk("data strobe", 16'h0000, {15'h0000, dsN});
        wReq = 1'b1;
        tick(2);
        chk("write strobes", 16'h0005, {13'h0000, dsN, wrN, pmN});
        chk("write enable", 16'hFFFF, dOe);
        chk("write data", 16'hA5C3, dOut);
        chk("write address", 16'h05A5, {4'h0, addr});
        go = 1'b1;
        tick(1);
        go = 1'b0;
        tick(5);
        chk("strobes", 16'h0007, {13'h0000, dsN, wrN, pmN});
        chk("data enable", 16'h0000, dOe);
        tick(8);
        chk("address", 16'h0000, {4'h0, addr});
        chk("counter", 16'h0000, {4'h0, pc});
        chk("in reset", 16'h0001, {15'h0000, inRst});
    endtask : t_reset
    task automatic t_release();
        fReq = 1'b1;
        n = 0;
        while (resetInN !== 1'b1 && n < 40) begin
            tick(1);
            n++;
        end
        n = 0;
        while (pmN !== 1'b0 && n < 30) begin
            tick(1);
            n++;
        end
        chk("fetch strobe", 16'h0000, {15'h0000, pmN});
        chk("restart delay ok", 16'h0001, 16'(n >= 4));
        chk("restart address", 16'h0000, {4'h0, addr});
        chk("restart counter", 16'h0001, {4'h0, pc});
        repeat (12) begin
            tick(1);
            chk("single strobe", 16'h0001, 16'($countones(~{dsN, wrN, pmN}) <= 1));
        end
    endtask : t_release
    task automatic end_sim();
        $display("checks %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : end_sim
    initial begin
        #40000;
        errors++;
        end_sim();
    end
    initial begin
        tick(4);
        rstB = 1'b1;
        tick(16);
        t_clock();
        t_sample();
        t_reset();
        t_release();
        end_sim();
    end
endmodule : dsp_core_reset_sync_tb_top
`default_nettype wire
